// >>> design/tlp_check.sv
// Packet malformed and routing screen with register slave
`default_nettype none
module tlp_check (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic [1:0]       avs_response_out,
  // Packet to check
  input  wire logic        chk_valid_in,
  input  wire logic        chk_egress_in,
  input  wire logic [63:0] chk_header_in,
  input  wire logic [10:0] chk_payload_dw_in,
  input  wire logic [10:0] chk_total_dw_in,
  // Routing results from the switch core
  input  wire logic        rte_back_in,
  input  wire logic        rte_none_in,
  input  wire logic        rte_up_only_in,
  input  wire logic        rte_to_up_in,
  input  wire logic        rte_vga_in,
  input  wire logic        rte_internal_in,
  input  wire logic        rte_thru_bridge_in,
  input  wire logic        rte_to_up_conv_in,
  input  wire logic        rte_dev_absent_in,
  input  wire logic        rte_conv_ds_in,
  input  wire logic        rte_port_target_in,
  // Outcome
  output logic             res_valid_out,
  output logic [2:0]       res_class_out,
  output logic [63:0]      res_header_out,
  output logic             fatal_out
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ctl;
    logic        rd_done;
    logic [31:0] rdata;
    logic [1:0]  resp;
    logic        vld;
    logic [2:0]  cls;
    logic [63:0] hdr;
    logic        fatal;
    logic [63:0] log_hdr;
    logic        log_full;
    logic [7:0]  mal_cnt;
  } state_t;
  state_t s_q, s_d;

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  function automatic logic [10:0] mps_dw(input logic [2:0] code);
    mps_dw = 11'(32 << code);
  endfunction : mps_dw

  function automatic logic [10:0] len_dw(input logic [9:0] len);
    len_dw = (len == 10'h000) ? 11'h400 : {1'b0, len};
  endfunction : len_dw

  function automatic logic ft_valid(input logic [6:0] ft);
    logic ok;
    ok = 1'b0;
    unique case (ft)
      tlp_check_pkg::FT_MRD3, tlp_check_pkg::FT_MRD4,
      tlp_check_pkg::FT_MWR3, tlp_check_pkg::FT_MWR4,
      tlp_check_pkg::FT_IORD, tlp_check_pkg::FT_IOWR,
      tlp_check_pkg::FT_CR0,  tlp_check_pkg::FT_CW0,
      tlp_check_pkg::FT_CR1,  tlp_check_pkg::FT_CW1,
      tlp_check_pkg::FT_CPL,  tlp_check_pkg::FT_CPLD,
      tlp_check_pkg::FT_TCR,  tlp_check_pkg::FT_TCW: ok = 1'b1;
      default: ok = (ft[4:3] == 2'b10);
    endcase
    ft_valid = ok;
  endfunction : ft_valid

  // ------------------------------------------------------------------
  // Header fields
  // ------------------------------------------------------------------
  logic [6:0]  ft;
  logic [2:0]  tc;
  logic        td;
  logic [1:0]  attr;
  logic [9:0]  len;
  logic [3:0]  last_be;
  logic [7:0]  msg_code;
  logic [4:0]  dev_num;
  logic        upstream;
  logic        is_msg, is_io, is_cfg, is_cfg1, is_cpl, is_mem, is_tcfg;
  logic        is_intx, tc0_msg, has_data;
  logic [10:0] hdr_dw, exp_total;

  always_comb begin
    ft       = chk_header_in[30:24];
    tc       = chk_header_in[22:20];
    td       = chk_header_in[15];
    attr     = chk_header_in[13:12];
    len      = chk_header_in[9:0];
    last_be  = chk_header_in[39:36];
    msg_code = chk_header_in[39:32];
    dev_num  = chk_header_in[63:59];
    upstream = s_q.ctl[tlp_check_pkg::CTL_UPSTREAM];
    has_data = ft[6];
    is_msg   = (ft[4:3] == 2'b10);
    is_io    = (ft[4:0] == 5'h02);
    is_cfg   = (ft[4:1] == 4'h2);
    is_cfg1  = (ft[4:0] == 5'h05);
    is_cpl   = (ft[4:0] == 5'h0A);
    is_mem   = (ft[4:0] == 5'h00);
    is_tcfg  = (ft[4:0] == 5'h1B);
    is_intx  = is_msg && (msg_code[7:3] == 5'b00100);
    tc0_msg  = is_msg && (is_intx || msg_code[7:4] == 4'h1 ||
               msg_code[7:4] == 4'h3 || msg_code == tlp_check_pkg::MC_UNLOCK ||
               msg_code == tlp_check_pkg::MC_SPL);
    hdr_dw   = ft[5] ? 11'h004 : 11'h003;
    exp_total = 11'(hdr_dw + (has_data ? len_dw(len) : 11'h000) +
                (td ? 11'h001 : 11'h000));
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  logic mal, ur, uc, drop;
  logic tc_unmapped;

  always_comb begin
    tc_unmapped = !s_q.ctl[tlp_check_pkg::CTL_MAP_LSB + 32'(tc)];
    mal = tc_unmapped;
    ur = 1'b0;
    uc = 1'b0;
    drop = 1'b0;
    if (!chk_egress_in) begin
      if (!ft_valid(ft) || len_dw(len) >
          mps_dw(s_q.ctl[tlp_check_pkg::CTL_MPS_LSB +: 3]))
        mal = 1'b1;
      if (has_data && len_dw(len) != chk_payload_dw_in)
        mal = 1'b1;
      if (td && chk_total_dw_in != exp_total)
        mal = 1'b1;
      if ((is_io || is_cfg) && (len != 10'h001 || tc != 3'h0 ||
          attr != 2'h0 || last_be != 4'h0))
        mal = 1'b1;
      if (tc0_msg && tc != 3'h0)
        mal = 1'b1;
      if (is_msg && ft[2:0] == tlp_check_pkg::RT_ROOT && upstream)
        mal = 1'b1;
      if (is_msg && ft[2:0] == tlp_check_pkg::RT_BCAST && !upstream)
        mal = 1'b1;
      if (is_msg && ft[2:0] == tlp_check_pkg::RT_GATHER &&
          (upstream || msg_code != tlp_check_pkg::MC_PME_TO_ACK))
        mal = 1'b1;
      if (is_intx && upstream)
        mal = 1'b1;
      if (is_tcfg && !upstream)
        mal = 1'b1;
      // Routing outcomes; malformed takes priority
      if (is_mem || is_io) begin
        if (rte_back_in || rte_up_only_in)
          ur = 1'b1;
        if (!rte_to_up_in && ((is_mem &&
            !s_q.ctl[tlp_check_pkg::CTL_MAE]) || (is_io &&
            !s_q.ctl[tlp_check_pkg::CTL_IO_ACCESS_ENABLE_BIT])))
          ur = 1'b1;
        if ((!upstream && !s_q.ctl[tlp_check_pkg::CTL_BME]) ||
            (rte_to_up_in && !s_q.ctl[tlp_check_pkg::CTL_UBME]))
          ur = 1'b1;
        if (rte_vga_in && !upstream && s_q.ctl[tlp_check_pkg::CTL_VGA])
          ur = 1'b1;
      end
      if (is_cfg && (!upstream || (is_cfg1 && !rte_thru_bridge_in) ||
          (rte_to_up_conv_in && rte_dev_absent_in)))
        ur = 1'b1;
      if (is_cfg1 && rte_conv_ds_in && dev_num != 5'h00 &&
          !s_q.ctl[tlp_check_pkg::CTL_DDNC])
        ur = 1'b1;
      if (is_cpl) begin
        if (rte_internal_in)
          uc = 1'b1;
        else if (rte_back_in || rte_none_in)
          ur = 1'b1;
      end
      if (is_msg && ft[2:0] == tlp_check_pkg::RT_ID &&
          (rte_back_in || rte_none_in || rte_dev_absent_in))
        ur = 1'b1;
      if (is_msg && (rte_port_target_in || upstream) &&
          ft[2:0] == tlp_check_pkg::RT_ID) begin
        if (msg_code == tlp_check_pkg::MC_VD1)
          drop = 1'b1;
        else if (msg_code[7:1] != 7'h3F)
          ur = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  logic bus_acc;
  always_comb begin
    s_d = s_q;
    s_d.fatal = 1'b0;
    s_d.vld = chk_valid_in;
    if (chk_valid_in) begin
      s_d.hdr = chk_header_in;
      if (mal)
        s_d.cls = tlp_check_pkg::CLS_MAL;
      else if (uc)
        s_d.cls = tlp_check_pkg::CLS_UC;
      else if (ur)
        s_d.cls = tlp_check_pkg::CLS_UR;
      else if (drop)
        s_d.cls = tlp_check_pkg::CLS_DROP;
      else
        s_d.cls = tlp_check_pkg::CLS_OK;
      if (mal) begin
        s_d.fatal = 1'b1;
        if (!s_q.log_full) begin
          s_d.log_hdr = chk_header_in;
          s_d.log_full = 1'b1;
        end
        if (s_q.mal_cnt != 8'hFF)
          s_d.mal_cnt = 8'(s_q.mal_cnt + 8'h01);
      end
    end
    bus_acc = (avs_read_in || avs_write_in) && !s_q.rd_done;
    s_d.rd_done = bus_acc;
    s_d.resp = 2'h0;
    s_d.rdata = 32'h0000_0000;
    if (bus_acc && avs_write_in) begin
      if (avs_address_in == tlp_check_pkg::OFF_CONTROL) begin
        for (int b = 0; b < 4; b++)
          if (avs_byteenable_in[b])
            s_d.ctl[8*b +: 8] = avs_writedata_in[8*b +: 8];
      end else if (avs_address_in == tlp_check_pkg::OFF_STATUS) begin
        // Write one clears the log; a malformed packet in the same cycle wins
        if (avs_writedata_in[0] && !(chk_valid_in && mal))
          s_d.log_full = 1'b0;
      end else
        s_d.resp = 2'h2;
    end
    if (bus_acc && avs_read_in) begin
      unique case (avs_address_in)
        tlp_check_pkg::OFF_CONTROL: s_d.rdata = s_q.ctl;
        tlp_check_pkg::OFF_STATUS:
          s_d.rdata = {16'h0000, s_q.mal_cnt, 7'h00, s_q.log_full};
        tlp_check_pkg::OFF_HDR0:    s_d.rdata = s_q.log_hdr[31:0];
        tlp_check_pkg::OFF_HDR1:    s_d.rdata = s_q.log_hdr[63:32];
        default:                    s_d.resp = 2'h2;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '0;
      s_q.ctl <= tlp_check_pkg::CTL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !s_q.rd_done;
  assign avs_readdata_out    = s_q.rdata;
  assign avs_response_out    = s_q.resp;
  assign res_valid_out       = s_q.vld;
  assign res_class_out       = s_q.cls;
  assign res_header_out      = s_q.hdr;
  assign fatal_out           = s_q.fatal;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_fatal_on_mal: assert property (chk_valid_in && mal |=> fatal_out &&
    res_class_out == tlp_check_pkg::CLS_MAL)
    else $error("malformed packet not fatal");
  a_result_one_cycle: assert property (chk_valid_in |=> res_valid_out &&
    res_header_out == $past(chk_header_in))
    else $error("result missing or header wrong");
  a_no_fatal_ok: assert property (!chk_valid_in |=> !fatal_out)
    else $error("fatal without packet");
  a_len_mismatch: assert property (chk_valid_in && !chk_egress_in &&
    has_data && len_dw(len) != chk_payload_dw_in |=>
    res_class_out == tlp_check_pkg::CLS_MAL)
    else $error("length mismatch not malformed");
  a_tc_map_check: assert property (chk_valid_in && tc_unmapped |=>
    res_class_out == tlp_check_pkg::CLS_MAL)
    else $error("unmapped class passed");
  a_cpl_internal: assert property (chk_valid_in && !mal && is_cpl &&
    rte_internal_in && !chk_egress_in |=>
    res_class_out == tlp_check_pkg::CLS_UC)
    else $error("internal completion not unexpected");
  a_io_cfg_len: assert property (chk_valid_in && !chk_egress_in &&
    (is_io || is_cfg) && len != 10'h001 |=> fatal_out)
    else $error("io or config length not screened");
  a_wait_one: assert property (avs_read_in && !s_q.rd_done |=>
    !avs_waitrequest_out)
    else $error("bus answer late");
endmodule : tlp_check
`default_nettype wire

// >>> design/tlp_check_pkg.sv
// Package of constants and types for the packet screening block
`default_nettype none
package tlp_check_pkg;
  // ------------------------------------------------------------------
  // Register map (word aligned byte addresses)
  // ------------------------------------------------------------------
  localparam logic [3:0] OFF_CONTROL   = 4'h0;
  localparam logic [3:0] OFF_STATUS    = 4'h4;
  localparam logic [3:0] OFF_HDR0      = 4'h8;
  localparam logic [3:0] OFF_HDR1      = 4'hC;
  // ------------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------------
  localparam int CTL_MPS_LSB  = 0;   // max_payload_size_field, 3 bits
  localparam int CTL_MAP_LSB  = 8;   // class_to_channel_map, 8 bits
  localparam int CTL_MAE      = 16;  // memory_access_enable_bit
  localparam int CTL_IO_ACCESS_ENABLE_BIT     = 17;  // io_access_enable_bit
  localparam int CTL_BME      = 18;  // bus_master_enable_bit
  localparam int CTL_UBME     = 19;  // upstream bus_master_enable_bit
  localparam int CTL_DDNC     = 20;  // disable_device_number_check_bit
  localparam int CTL_VGA      = 21;  // downstream port vga enable
  localparam int CTL_UPSTREAM = 22;  // this port is the upstream port
  localparam logic [31:0] CTL_RESET = 32'h0000_FF00;
  // ------------------------------------------------------------------
  // Header decoding
  // ------------------------------------------------------------------
  localparam logic [6:0] FT_MRD3 = 7'h00, FT_MRD4 = 7'h20,
                         FT_MWR3 = 7'h40, FT_MWR4 = 7'h60,
                         FT_IORD = 7'h02, FT_IOWR = 7'h42,
                         FT_CR0  = 7'h04, FT_CW0  = 7'h44,
                         FT_CR1  = 7'h05, FT_CW1  = 7'h45,
                         FT_CPL  = 7'h0A, FT_CPLD = 7'h4A,
                         FT_TCR  = 7'h1B, FT_TCW  = 7'h5B;
  localparam logic [2:0] RT_ROOT = 3'h0, RT_ADDR = 3'h1, RT_ID = 3'h2,
                         RT_BCAST = 3'h3, RT_GATHER = 3'h5;
  localparam logic [7:0] MC_PME_TO_ACK = 8'h1B, MC_UNLOCK = 8'h00,
                         MC_SPL = 8'h50, MC_VD1 = 8'h7F,
                         MC_VD0 = 8'h7E;
  localparam logic [1:0] HDR3_DW = 2'h3, HDR4_DW = 2'h0;
  typedef enum logic [2:0] {
    CLS_OK = 3'b000, CLS_MAL = 3'b001, CLS_UR = 3'b010,
    CLS_UC = 3'b011, CLS_DROP = 3'b100
  } cls_t;
endpackage : tlp_check_pkg
`default_nettype wire

// >>> test/tlp_check_bench.sv
// Self-checking bench for the packet screening block
`default_nettype none
module tlp_check_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] OK = tlp_check_pkg::CLS_OK,
    MAL = tlp_check_pkg::CLS_MAL, UR = tlp_check_pkg::CLS_UR,
    UC = tlp_check_pkg::CLS_UC, DRP = tlp_check_pkg::CLS_DROP;
  logic clk_in, rstn_in, rd, wr, vld, egr, td, eg;
  logic [3:0] addr;
  logic [31:0] wdata, q, avs_readdata_out;
  logic [1:0] r, attr, avs_response_out;
  logic [63:0] hdr_w, first, res_header_out;
  logic [10:0] pay_w, tot_w, rte_w, xtra;
  logic [4:0] dev;
  logic [7:0] nmal;
  logic [2:0] res_class_out;
  logic avs_waitrequest_out, res_valid_out, fatal_out;
  int bad_count, cmp_count;
  // Route bits: back none up_only to_up vga internal thru_bridge
  // to_up_conv dev_absent conv_ds port_target, msb first
  tlp_fabric_model tlp_fabric_model_i (.clk_in(clk_in), .valid_out(vld),
    .egress_out(egr), .header_out(hdr_w), .payload_dw_out(pay_w),
    .total_dw_out(tot_w), .route_out(rte_w));
  tlp_check tlp_check_i (.clk_in(clk_in), .rstn_in(rstn_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .avs_response_out(avs_response_out), .chk_valid_in(vld),
    .chk_egress_in(egr), .chk_header_in(hdr_w), .chk_payload_dw_in(pay_w),
    .chk_total_dw_in(tot_w), .rte_back_in(rte_w[10]),
    .rte_none_in(rte_w[9]), .rte_up_only_in(rte_w[8]),
    .rte_to_up_in(rte_w[7]), .rte_vga_in(rte_w[6]),
    .rte_internal_in(rte_w[5]), .rte_thru_bridge_in(rte_w[4]),
    .rte_to_up_conv_in(rte_w[3]), .rte_dev_absent_in(rte_w[2]),
    .rte_conv_ds_in(rte_w[1]), .rte_port_target_in(rte_w[0]),
    .res_valid_out(res_valid_out), .res_class_out(res_class_out),
    .res_header_out(res_header_out), .fatal_out(fatal_out));
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  always #50 clk_in = ~clk_in;
  task automatic conclude;
    if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic cmp(input logic [63:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : cmp
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= ~w;
    wr <= w;
    wdata <= d;
    // Hold the request until waitrequest is seen low at a rising edge
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    r = avs_response_out;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    cmp(64'(q), 64'(e));
    cmp(64'(r), 64'h0);
  endtask : rd_reg
  task automatic ctl(input logic [31:0] d);
    bus(tlp_check_pkg::OFF_CONTROL, 1'b1, d);
    cmp(64'(r), 64'h0);
  endtask : ctl
  task automatic go(input logic [6:0] ft, input logic [2:0] tc,
                    input logic [9:0] len, input logic [7:0] b1,
                    input logic [10:0] pay, rte, input logic [2:0] c);
    logic [63:0] h;
    logic [10:0] tot;
    h = {dev, 19'h0, b1, 1'b0, ft, 1'b0, tc, 4'h0, td, 1'b0, attr, 2'h0, len};
    tot = (ft[5] ? 11'h4 : 11'h3) + pay + {10'h0, td} + xtra;
    tlp_fabric_model_i.send(h, pay, tot, rte, eg);
    @(negedge clk_in);
    cmp(64'(res_valid_out), 64'h1);
    cmp(64'(res_class_out), 64'(c));
    cmp(res_header_out, h);
    cmp(64'(fatal_out), 64'(c == MAL));
    if (c == MAL && nmal == 8'h0) first = h;
    if (c == MAL) nmal++;
  endtask : go
  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    clk_in = 1'b0; rstn_in = 1'b0; rd = 1'b0; wr = 1'b0; addr = 4'h0;
    wdata = 32'h0; td = 1'b0; eg = 1'b0; attr = 2'h0; dev = 5'h0;
    xtra = 11'h0; nmal = 8'h0; first = 64'h0; bad_count = 0; cmp_count = 0;
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd_reg(tlp_check_pkg::OFF_CONTROL, tlp_check_pkg::CTL_RESET);
    bus(4'h2, 1'b0, 32'h0);
    cmp(64'(r), 64'h2);
    ctl(32'h0007_FF00);
    go(7'h1F, 3'h0, 10'h0, 8'h0, 11'h0, 11'h0, MAL);
    go(7'h00, 3'h0, 10'h20, 8'h0, 11'h0, 11'h0, OK);
    go(7'h00, 3'h0, 10'h21, 8'h0, 11'h0, 11'h0, MAL);
    go(7'h40, 3'h0, 10'h4, 8'h0, 11'h3, 11'h0, MAL);
    go(7'h40, 3'h0, 10'h4, 8'h0, 11'h4, 11'h0, OK);
    td = 1'b1;
    xtra = 11'h7FF;
    go(7'h40, 3'h0, 10'h4, 8'h0, 11'h4, 11'h0, MAL);
    xtra = 11'h0;
    go(7'h40, 3'h0, 10'h4, 8'h0, 11'h4, 11'h0, OK);
    td = 1'b0;
    go(7'h02, 3'h0, 10'h2, 8'h0F, 11'h0, 11'h0, MAL);
    go(7'h02, 3'h1, 10'h1, 8'h0F, 11'h0, 11'h0, MAL);
    attr = 2'h1;
    go(7'h02, 3'h0, 10'h1, 8'h0F, 11'h0, 11'h0, MAL);
    attr = 2'h0;
    go(7'h02, 3'h0, 10'h1, 8'h1F, 11'h0, 11'h0, MAL);
    go(7'h42, 3'h0, 10'h1, 8'h0F, 11'h1, 11'h0, OK);
    go(7'h04, 3'h0, 10'h2, 8'h0F, 11'h0, 11'h0, MAL);
    go(7'h34, 3'h1, 10'h1, 8'h20, 11'h0, 11'h0, MAL);
    go(7'h34, 3'h0, 10'h1, 8'h20, 11'h0, 11'h0, OK);
    go(7'h30, 3'h0, 10'h1, 8'h30, 11'h0, 11'h0, OK);
    go(7'h33, 3'h0, 10'h1, 8'h00, 11'h0, 11'h0, MAL);
    go(7'h35, 3'h0, 10'h1, 8'h1B, 11'h0, 11'h0, OK);
    go(7'h35, 3'h0, 10'h1, 8'h20, 11'h0, 11'h0, MAL);
    go(7'h1B, 3'h0, 10'h1, 8'h0F, 11'h0, 11'h0, MAL);
    go(7'h00, 3'h0, 10'h1, 8'h0F, 11'h0, 11'h400, UR);
    go(7'h00, 3'h0, 10'h1, 8'h0F, 11'h0, 11'h100, UR);
    go(7'h00, 3'h0, 10'h1, 8'h0F, 11'h0, 11'h080, UR);
    go(7'h00, 3'h0, 10'h1, 8'h0F, 11'h0, 11'h040, OK);
    go(7'h04, 3'h0, 10'h1, 8'h0F, 11'h0, 11'h0, UR);
    go(7'h05, 3'h0, 10'h1, 8'h0F, 11'h0, 11'h0, UR);
    go(7'h4A, 3'h0, 10'h1, 8'h0, 11'h1, 11'h400, UR);
    go(7'h4A, 3'h0, 10'h1, 8'h0, 11'h1, 11'h200, UR);
    go(7'h4A, 3'h0, 10'h1, 8'h0, 11'h1, 11'h020, UC);
    go(7'h4A, 3'h0, 10'h1, 8'h0, 11'h1, 11'h420, UC);
    go(7'h32, 3'h0, 10'h1, 8'h7E, 11'h0, 11'h004, UR);
    go(7'h32, 3'h0, 10'h1, 8'h7E, 11'h0, 11'h400, UR);
    go(7'h32, 3'h0, 10'h1, 8'h7F, 11'h0, 11'h001, DRP);
    go(7'h32, 3'h0, 10'h1, 8'h44, 11'h0, 11'h001, UR);
    eg = 1'b1;
    go(7'h1F, 3'h0, 10'h0, 8'h0, 11'h0, 11'h0, OK);
    ctl(32'h0007_FE00);
    go(7'h00, 3'h0, 10'h1, 8'h0F, 11'h0, 11'h0, MAL);
    eg = 1'b0;
    go(7'h00, 3'h0, 10'h1, 8'h0F, 11'h0, 11'h0, MAL);
    go(7'h00, 3'h1, 10'h1, 8'h0F, 11'h0, 11'h0, OK);
    ctl(32'h0006_FF00);
    go(7'h00, 3'h0, 10'h1, 8'h0F, 11'h0, 11'h0, UR);
    ctl(32'h0005_FF00);
    go(7'h02, 3'h0, 10'h1, 8'h0F, 11'h0, 11'h0, UR);
    ctl(32'h0003_FF00);
    go(7'h00, 3'h0, 10'h1, 8'h0F, 11'h0, 11'h0, UR);
    ctl(32'h0027_FF00);
    go(7'h00, 3'h0, 10'h1, 8'h0F, 11'h0, 11'h040, UR);
    ctl(32'h004F_FF00);
    go(7'h34, 3'h0, 10'h1, 8'h20, 11'h0, 11'h0, MAL);
    go(7'h30, 3'h0, 10'h1, 8'h30, 11'h0, 11'h0, MAL);
    go(7'h35, 3'h0, 10'h1, 8'h1B, 11'h0, 11'h0, MAL);
    go(7'h33, 3'h0, 10'h1, 8'h00, 11'h0, 11'h0, OK);
    go(7'h33, 3'h2, 10'h1, 8'h00, 11'h0, 11'h0, MAL);
    go(7'h32, 3'h0, 10'h1, 8'h44, 11'h0, 11'h0, UR);
    go(7'h05, 3'h0, 10'h1, 8'h0F, 11'h0, 11'h0, UR);
    go(7'h05, 3'h0, 10'h1, 8'h0F, 11'h0, 11'h01C, UR);
    dev = 5'h01;
    go(7'h05, 3'h0, 10'h1, 8'h0F, 11'h0, 11'h012, UR);
    ctl(32'h005F_FF00);
    go(7'h05, 3'h0, 10'h1, 8'h0F, 11'h0, 11'h012, OK);
    rd_reg(tlp_check_pkg::OFF_STATUS, {16'h0, nmal, 8'h01});
    rd_reg(tlp_check_pkg::OFF_HDR0, first[31:0]);
    rd_reg(tlp_check_pkg::OFF_HDR1, first[63:32]);
    bus(tlp_check_pkg::OFF_STATUS, 1'b1, 32'h1);
    rd_reg(tlp_check_pkg::OFF_STATUS, {16'h0, nmal, 8'h00});
    conclude();
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    bad_count++;
    conclude();
  end
endmodule : tlp_check_bench
`default_nettype wire

// >>> test/tlp_fabric_model.sv
// Switch core side model that presents packets and route results
`default_nettype none
module tlp_fabric_model (
  input  wire logic   clk_in,
  output logic        valid_out,
  output logic        egress_out,
  output logic [63:0] header_out,
  output logic [10:0] payload_dw_out,
  output logic [10:0] total_dw_out,
  output logic [10:0] route_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    valid_out = 1'b0;
    egress_out = 1'b0;
    header_out = 64'h0;
    payload_dw_out = 11'h0;
    total_dw_out = 11'h0;
    route_out = 11'h0;
  end
  // One packet for one cycle, then the released lines are scrambled
  task automatic send(input logic [63:0] h, input logic [10:0] pay, tot,
                      input logic [10:0] rte, input logic eg);
    @(posedge clk_in);
    valid_out <= 1'b1;
    egress_out <= eg;
    header_out <= h;
    payload_dw_out <= pay;
    total_dw_out <= tot;
    route_out <= rte;
    @(posedge clk_in);
    valid_out <= 1'b0;
    egress_out <= ~eg;
    header_out <= ~h;
    payload_dw_out <= ~pay;
    total_dw_out <= ~tot;
    route_out <= ~rte;
  endtask : send
endmodule : tlp_fabric_model
`default_nettype wire
